// file: hw/phyc_pkg.sv
// Package: constants for the transceiver control register block
package phyc_pkg;

  // Frame layout
  localparam int FRAME_W         = 16;
  localparam int HDR_W           = 4;
  localparam int DATA_W          = 12;
  localparam int ADDR_HI_POS     = 15;
  localparam int ADDR_LO_POS     = 14;
  localparam int RD_SEL_POS      = 13;
  localparam int RD_ONLY_POS     = 12;
  localparam logic [1:0] REG_SEL_PHY = 2'b11;

  // Field positions in the 12-bit settings word
  localparam int CAN_SUPPLY_OFFLINE_POS = 11;
  localparam int PARTIAL_LISTEN_POS     = 10;
  localparam int OFFLINE_TIMEOUT_POS    = 9;
  localparam int CAN_TX_DISABLE_POS     = 8;
  localparam int CAN_LOOPBACK_POS       = 7;
  localparam int CAN_ACTIVE_POS         = 6;
  localparam int CAN_SPLIT_POS          = 5;
  localparam int LIN_ACTIVE_POS         = 4;
  localparam int LIN_LOW_SLOPE_POS      = 3;
  localparam int LIN_STRONG_DRIVE_POS   = 2;
  localparam int LIN_WAKEUP_EN_POS      = 1;
  localparam int LIN_TX_DISABLE_POS     = 0;

  // Reset value of the settings word
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // Off-line bus-idle times and their cycle counts at the system clock
  localparam int CLK_MHZ            = 50;
  localparam int T_OFFLINE_SHORT_US = 40;
  localparam int T_OFFLINE_LONG_US  = 200;
  localparam int T_OFFLINE_EXT_US   = 1000;
  localparam int OFFLINE_SHORT_CYC  = T_OFFLINE_SHORT_US * CLK_MHZ;
  localparam int OFFLINE_LONG_CYC   = T_OFFLINE_LONG_US * CLK_MHZ;
  localparam int OFFLINE_EXT_CYC    = T_OFFLINE_EXT_US * CLK_MHZ;
  localparam int IDLE_CNT_W         = 20;

  // CAN transceiver states, one-hot
  typedef enum logic [2:0] {
    CAN_OFFLINE = 3'b001,
    CAN_ONLINE  = 3'b010,
    CAN_LISTEN  = 3'b100
  } phyc_can_state_type;

endpackage : phyc_pkg

// file: hw/phyc_spi_frame.sv
// Serial frame shifter: 16-bit frames, sample on rising clock, shift on falling
module phyc_spi_frame
  import phyc_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      spi_sck,
  input  wire logic                      spi_cs_n,
  input  wire logic                      spi_sdi,
  output logic                           spi_sdo,
  output logic                           spi_sdo_oe,
  output logic                           hdr_valid,
  output logic [phyc_pkg::HDR_W-1:0]     hdr_bits,
  input  wire logic [phyc_pkg::DATA_W-1:0] reply_data,
  output logic                           frame_done,
  output logic [phyc_pkg::FRAME_W-1:0]   frame_data
);
  import phyc_pkg::*;

  logic                sck_q, sck_d;
  logic                cs_q, cs_d;
  logic [FRAME_W-1:0]  rx_q, rx_d;
  logic [FRAME_W-1:0]  tx_q, tx_d;
  logic [4:0]          cnt_q, cnt_d;
  logic                sdo_q, sdo_d;
  logic                oe_q, oe_d;
  logic                hv_q, hv_d;
  logic                fd_q, fd_d;
  logic                rise;
  logic                fall;

  assign rise       = spi_sck & ~sck_q;
  assign fall       = ~spi_sck & sck_q;
  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = oe_q;
  assign hdr_valid  = hv_q;
  assign hdr_bits   = rx_q[HDR_W-1:0];
  assign frame_done = fd_q;
  assign frame_data = rx_q;

  always_comb begin
    sck_d = spi_sck;
    cs_d  = ~spi_cs_n;
    rx_d  = rx_q;
    tx_d  = tx_q;
    cnt_d = cnt_q;
    sdo_d = sdo_q;
    oe_d  = ~spi_cs_n;
    hv_d  = 1'b0;
    fd_d  = 1'b0;
    if (!spi_cs_n && !cs_q) begin
      // Frame start: header bits of the reply read as zero
      cnt_d = 5'h00;
      tx_d  = '0;
      sdo_d = 1'b0;
    end else if (!spi_cs_n) begin
      if (rise && cnt_q < 5'(FRAME_W)) begin
        rx_d  = {rx_q[FRAME_W-2:0], spi_sdi};
        cnt_d = cnt_q + 5'h01;
        hv_d  = (cnt_q == 5'(HDR_W - 1));
      end
      if (fall) begin
        tx_d  = {tx_q[FRAME_W-2:0], 1'b0};
        sdo_d = tx_q[FRAME_W-2];
      end
      if (hv_q) begin
        // Reply payload placed so the next falling edge shifts its top bit out
        tx_d  = {1'b0, reply_data, 3'h0};
      end
    end else if (cs_q) begin
      // Only a frame of 16 or more bits is handed on; clocks after the 16th are ignored
      fd_d  = (cnt_q == 5'(FRAME_W));
      sdo_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b0;
      rx_q  <= '0;
      tx_q  <= '0;
      cnt_q <= 5'h00;
      sdo_q <= 1'b0;
      oe_q  <= 1'b0;
      hv_q  <= 1'b0;
      fd_q  <= 1'b0;
    end else begin
      sck_q <= sck_d;
      cs_q  <= cs_d;
      rx_q  <= rx_d;
      tx_q  <= tx_d;
      cnt_q <= cnt_d;
      sdo_q <= sdo_d;
      oe_q  <= oe_d;
      hv_q  <= hv_d;
      fd_q  <= fd_d;
    end
  end

endmodule : phyc_spi_frame

// file: hw/phyc_phy_control.sv
// Transceiver control register with serial access and CAN/LIN control outputs
// Summary of operation
// [R1] Address code 11 selects this register
// [R2] Read-select 1 returns general purpose feedback
// [R3] Read-select 0 returns stored settings
// [R4] Read-only 1 leaves settings unchanged
// [R5] Read-only 0 loads frame fields into settings
// [R6] Supply bit 1 turns regulator off off-line
// [R7] Partial-network bit selects listen-only on-line state
// [R8] Partial-network bit cleared entering On-line/Active
// [R9] Off-line after idle time, length bit-selected, extended length after a wake event
// [R10] CAN transmitter disabled when control bit 1
// [R11] Interface failure disables transmitter, bit untouched
// [R12] Good CAN traffic re-enables transmitter
// [R13] Writing control bit 1 then 0 recovers
// [R14] Loopback when receiver bit and disable set
// [R15] CAN active only in Normal or Flash
// [R16] Split bit drives split pin, else floating
// [R17] LIN active only in Normal or Flash
// [R18] LIN slope bit selects low slope driver
// [R19] LIN drive bit selects increased current
// [R20] LIN wake enable gates LIN wake-up
// [R21] LIN transmitter disabled when control bit 1
// [R22] Damaged positions fixed: 9, 8, 4, 1, 0
module phyc_phy_control
  import phyc_pkg::*;
#(
  parameter int OFFLINE_SHORT_CYCLES = phyc_pkg::OFFLINE_SHORT_CYC,
  parameter int OFFLINE_LONG_CYCLES  = phyc_pkg::OFFLINE_LONG_CYC,
  parameter int OFFLINE_EXT_CYCLES   = phyc_pkg::OFFLINE_EXT_CYC
)
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        spi_sck,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_sdi,
  output logic                             spi_sdo,
  output logic                             spi_sdo_oe,
  input  wire logic [phyc_pkg::DATA_W-1:0] gp_feedback1,
  input  wire logic                        sbc_normal_or_flash,
  input  wire logic                        sbc_enter_online_active,
  input  wire logic                        can_go_online,
  input  wire logic                        can_bus_activity,
  input  wire logic                        can_wake_event,
  input  wire logic                        can_iface_fail,
  input  wire logic                        can_good_traffic,
  input  wire logic                        can_tx_line,
  input  wire logic                        can_bus_rx,
  input  wire logic                        lin_bus_wake,
  output logic                             can_rx_line,
  output logic                             can_tx_enable,
  output logic                             can_listen_only,
  output logic                             can_offline,
  output logic                             can_transceiver_regulator,
  output logic                             can_active,
  output logic                             can_split_drive,
  output logic                             lin_active,
  output logic                             lin_low_slope,
  output logic                             lin_strong_drive,
  output logic                             lin_wakeup,
  output logic                             lin_tx_enable
);
  import phyc_pkg::*;

  logic                      hdr_valid;
  logic [HDR_W-1:0]          hdr_bits;
  logic                      frame_done;
  logic [FRAME_W-1:0]        frame_data;
  logic [DATA_W-1:0]         reply_data;

  logic [DATA_W-1:0]         ctrl_q, ctrl_d;
  logic                      fail_q, fail_d;
  logic                      write_en;

  phyc_can_state_type        state_q, state_d;
  logic [IDLE_CNT_W-1:0]     idle_q, idle_d;
  logic                      woke_q, woke_d;
  logic [IDLE_CNT_W-1:0]     idle_limit;

  logic                      rx_line_q, rx_line_d;
  logic                      tx_en_q, tx_en_d;
  logic                      listen_q, listen_d;
  logic                      offline_q, offline_d;
  logic                      reg_on_q, reg_on_d;
  logic                      can_act_q, can_act_d;
  logic                      split_q, split_d;
  logic                      lin_act_q, lin_act_d;
  logic                      slope_q, slope_d;
  logic                      strong_q, strong_d;
  logic                      lwake_q, lwake_d;
  logic                      lin_tx_q, lin_tx_d;

  function automatic logic sel_phy(input logic [HDR_W-1:0] hdr);
    sel_phy = (hdr[HDR_W-1 -: 2] == REG_SEL_PHY); // [R1]
  endfunction : sel_phy

  phyc_spi_frame u_spi (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .spi_sck    (spi_sck),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .hdr_valid  (hdr_valid),
    .hdr_bits   (hdr_bits),
    .reply_data (reply_data),
    .frame_done (frame_done),
    .frame_data (frame_data)
  );

  // Reply source chosen from the header of this frame
  always_comb begin
    reply_data = '0;
    if (sel_phy(hdr_bits)) begin
      if (hdr_bits[RD_SEL_POS-DATA_W]) begin
        reply_data = gp_feedback1; // [R2]
      end else begin
        reply_data = ctrl_q; // [R3]
      end
    end
  end

  // Settings register and interface failure flag
  assign write_en = frame_done && sel_phy(frame_data[ADDR_HI_POS -: HDR_W])
                    && !frame_data[RD_ONLY_POS]; // [R4] [R5]

  always_comb begin
    ctrl_d = ctrl_q;
    fail_d = fail_q;
    if (write_en) begin
      ctrl_d = frame_data[DATA_W-1:0]; // [R5]
    end
    if (sbc_enter_online_active) begin
      ctrl_d[PARTIAL_LISTEN_POS] = 1'b0; // [R8]
    end
    if (can_good_traffic) begin
      fail_d = 1'b0; // [R12]
    end
    if (ctrl_q[CAN_TX_DISABLE_POS] && !ctrl_d[CAN_TX_DISABLE_POS]) begin
      fail_d = 1'b0; // [R13]
    end
    if (can_iface_fail) begin
      fail_d = 1'b1; // [R11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      fail_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      fail_q <= fail_d;
    end
  end

  // CAN transceiver on-line / listen / off-line sequencing
  always_comb begin
    if (woke_q) begin
      idle_limit = IDLE_CNT_W'(OFFLINE_EXT_CYCLES);
    end else if (ctrl_q[OFFLINE_TIMEOUT_POS]) begin
      idle_limit = IDLE_CNT_W'(OFFLINE_LONG_CYCLES); // [R9]
    end else begin
      idle_limit = IDLE_CNT_W'(OFFLINE_SHORT_CYCLES); // [R9]
    end
  end

  always_comb begin
    state_d = state_q;
    idle_d  = idle_q;
    woke_d  = woke_q | can_wake_event;
    case (state_q)
      CAN_OFFLINE: begin
        idle_d = '0;
        if (can_go_online) begin
          state_d = ctrl_q[PARTIAL_LISTEN_POS] ? CAN_LISTEN : CAN_ONLINE; // [R7]
        end
      end
      CAN_ONLINE, CAN_LISTEN: begin
        state_d = ctrl_q[PARTIAL_LISTEN_POS] ? CAN_LISTEN : CAN_ONLINE; // [R7]
        if (can_bus_activity) begin
          idle_d = '0;
        end else if (idle_q >= idle_limit - IDLE_CNT_W'(1)) begin
          state_d = CAN_OFFLINE; // [R9]
          idle_d  = '0;
          woke_d  = 1'b0;
        end else begin
          idle_d = idle_q + IDLE_CNT_W'(1);
        end
      end
      default: begin
        state_d = CAN_OFFLINE;
        idle_d  = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= CAN_OFFLINE;
      idle_q  <= '0;
      woke_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      idle_q  <= idle_d;
      woke_q  <= woke_d;
    end
  end

  // Registered transceiver controls
  always_comb begin
    tx_en_d   = !ctrl_q[CAN_TX_DISABLE_POS] && !fail_q; // [R10] [R11]
    rx_line_d = (ctrl_q[CAN_LOOPBACK_POS] && ctrl_q[CAN_TX_DISABLE_POS]) ? can_tx_line : can_bus_rx; // [R14]
    listen_d  = (state_q == CAN_LISTEN);
    offline_d = (state_q == CAN_OFFLINE);
    reg_on_d  = !((state_q == CAN_OFFLINE) && ctrl_q[CAN_SUPPLY_OFFLINE_POS]); // [R6]
    can_act_d = ctrl_q[CAN_ACTIVE_POS] && sbc_normal_or_flash; // [R15]
    split_d   = ctrl_q[CAN_SPLIT_POS]; // [R16]
    lin_act_d = ctrl_q[LIN_ACTIVE_POS] && sbc_normal_or_flash; // [R17] [R22]
    slope_d   = ctrl_q[LIN_LOW_SLOPE_POS]; // [R18]
    strong_d  = ctrl_q[LIN_STRONG_DRIVE_POS]; // [R19]
    lwake_d   = ctrl_q[LIN_WAKEUP_EN_POS] && lin_bus_wake; // [R20]
    lin_tx_d  = !ctrl_q[LIN_TX_DISABLE_POS]; // [R21]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_line_q <= 1'b1;
      tx_en_q   <= 1'b0;
      listen_q  <= 1'b0;
      offline_q <= 1'b1;
      reg_on_q  <= 1'b1;
      can_act_q <= 1'b0;
      split_q   <= 1'b0;
      lin_act_q <= 1'b0;
      slope_q   <= 1'b0;
      strong_q  <= 1'b0;
      lwake_q   <= 1'b0;
      lin_tx_q  <= 1'b0;
    end else begin
      rx_line_q <= rx_line_d;
      tx_en_q   <= tx_en_d;
      listen_q  <= listen_d;
      offline_q <= offline_d;
      reg_on_q  <= reg_on_d;
      can_act_q <= can_act_d;
      split_q   <= split_d;
      lin_act_q <= lin_act_d;
      slope_q   <= slope_d;
      strong_q  <= strong_d;
      lwake_q   <= lwake_d;
      lin_tx_q  <= lin_tx_d;
    end
  end

  assign can_rx_line               = rx_line_q;
  assign can_tx_enable             = tx_en_q;
  assign can_listen_only           = listen_q;
  assign can_offline               = offline_q;
  assign can_transceiver_regulator = reg_on_q;
  assign can_active                = can_act_q;
  assign can_split_drive           = split_q;
  assign lin_active                = lin_act_q;
  assign lin_low_slope             = slope_q;
  assign lin_strong_drive          = strong_q;
  assign lin_wakeup                = lwake_q;
  assign lin_tx_enable             = lin_tx_q;

endmodule : phyc_phy_control

// file: tb/phyc_phy_control_assertions.sv
// Checker: port-level properties of the transceiver control block
module phyc_phy_control_assertions #(
  parameter int OFFLINE_SHORT_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sbc_normal_or_flash,
  input wire logic sbc_enter_online_active,
  input wire logic can_bus_activity,
  input wire logic can_iface_fail,
  input wire logic can_tx_line,
  input wire logic can_bus_rx,
  input wire logic lin_bus_wake,
  input wire logic can_rx_line,
  input wire logic can_tx_enable,
  input wire logic can_listen_only,
  input wire logic can_offline,
  input wire logic can_transceiver_regulator,
  input wire logic can_active,
  input wire logic lin_active,
  input wire logic lin_wakeup
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  // Consecutive bus-idle cycles
  always_comb begin
    idle_d = idle_q;
    if (can_bus_activity)
      idle_d = 16'h0000;
    else if (idle_q != 16'hffff)
      idle_d = idle_q + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    if (rst)
      idle_q <= 16'h0000;
    else
      idle_q <= idle_d;
  end
  sequence s_tx_off;
    ##[1:2] !can_tx_enable;
  endsequence
  sequence s_listen_clear;
    ##[1:3] !can_listen_only;
  endsequence
  AST_REG_OFFLINE: assert property (!can_transceiver_regulator |-> can_offline || $past(can_offline))
    else $error("regulator off while on-line");
  AST_LISTEN_ONLINE: assert property (can_listen_only |-> !can_offline)
    else $error("listen while off-line");
  AST_PN_CLEAR: assert property (sbc_enter_online_active |-> s_listen_clear)
    else $error("listen not cleared");
  AST_IDLE_TIME: assert property ($rose(can_offline) |-> idle_q >= 16'(OFFLINE_SHORT_CYCLES - 1))
    else $error("off-line too early");
  AST_FAIL_TX: assert property (can_iface_fail |-> s_tx_off)
    else $error("transmitter kept on after failure");
  AST_LOOPBACK: assert property ((can_rx_line != $past(can_bus_rx)) |->
    (can_rx_line == $past(can_tx_line)) && !can_tx_enable)
    else $error("receive line wrong");
  AST_CAN_ACT: assert property (can_active |-> $past(sbc_normal_or_flash))
    else $error("can active outside mode");
  AST_LIN_ACT: assert property (lin_active |-> $past(sbc_normal_or_flash))
    else $error("lin active outside mode");
  AST_LIN_WAKE: assert property (lin_wakeup |-> $past(lin_bus_wake))
    else $error("lin wake without bus event");
endmodule : phyc_phy_control_assertions

bind phyc_phy_control phyc_phy_control_assertions #(.OFFLINE_SHORT_CYCLES(OFFLINE_SHORT_CYCLES)) u_chk (
  .clk_sys, .rst, .sbc_normal_or_flash, .sbc_enter_online_active, .can_bus_activity,
  .can_iface_fail, .can_tx_line, .can_bus_rx, .lin_bus_wake, .can_rx_line, .can_tx_enable,
  .can_listen_only, .can_offline, .can_transceiver_regulator, .can_active, .lin_active, .lin_wakeup);

// file: tb/phyc_host_model.sv
// Host model: 16-bit serial frames, clock idle low
module phyc_host_model (
  input wire logic clk_sys,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b1;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= tx[i];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rx[i] = spi_sdo;
      @(posedge clk_sys);
      spi_sck <= 1'b1;
      repeat (3) @(posedge clk_sys);
      spi_sck <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_sdi <= ~tx[0];
    repeat (6) @(posedge clk_sys);
  endtask : xfer
endmodule : phyc_host_model

// file: tb/testbench.sv
// Testbench: serial access and control outputs of the transceiver block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SHORT = 8;
  localparam int LONG = 16;
  localparam int EXT = 32;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [11:0] gp_feedback1 = 12'h3c9;
  logic sbc_normal_or_flash = 1'b0, sbc_enter_online_active = 1'b0;
  logic can_go_online = 1'b0, can_bus_activity = 1'b0, can_wake_event = 1'b0;
  logic can_iface_fail = 1'b0, can_good_traffic = 1'b0;
  logic can_tx_line = 1'b0, can_bus_rx = 1'b1, lin_bus_wake = 1'b0;
  logic can_rx_line, can_tx_enable, can_listen_only, can_offline;
  logic can_transceiver_regulator, can_active, can_split_drive, lin_active;
  logic lin_low_slope, lin_strong_drive, lin_wakeup, lin_tx_enable;
  logic [15:0] rx;
  logic [11:0] v;
  int err_total = 0;
  int compares = 0;
  always #10 clk_sys = ~clk_sys;
  phyc_phy_control #(.OFFLINE_SHORT_CYCLES(SHORT), .OFFLINE_LONG_CYCLES(LONG), .OFFLINE_EXT_CYCLES(EXT)) uut (
    .clk_sys, .rst, .spi_sck, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe, .gp_feedback1,
    .sbc_normal_or_flash, .sbc_enter_online_active, .can_go_online, .can_bus_activity,
    .can_wake_event, .can_iface_fail, .can_good_traffic, .can_tx_line, .can_bus_rx,
    .lin_bus_wake, .can_rx_line, .can_tx_enable, .can_listen_only, .can_offline,
    .can_transceiver_regulator, .can_active, .can_split_drive, .lin_active,
    .lin_low_slope, .lin_strong_drive, .lin_wakeup, .lin_tx_enable);
  phyc_host_model host (.clk_sys, .spi_sck, .spi_cs_n, .spi_sdi, .spi_sdo);
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic [3:0] hd, input logic [11:0] d);
    fork
      host.xfer({hd, d}, rx);
      begin
        wt(8);
        chk("sdo_oe", {15'h0, spi_sdo_oe}, 16'h1);
      end
    join
    wt(4);
    chk("sdo_oe", {15'h0, spi_sdo_oe}, 16'h0);
  endtask : acc
  task automatic rd(input logic [11:0] exp);
    acc(4'hd, 12'h000);
    chk("readback", rx, {4'h0, exp});
  endtask : rd
  task automatic pls(input int k);
    case (k)
      0: can_iface_fail <= 1'b1;
      1: can_good_traffic <= 1'b1;
      2: can_go_online <= 1'b1;
      default: sbc_enter_online_active <= 1'b1;
    endcase
    wt(1);
    {can_wake_event, can_iface_fail, can_good_traffic, can_go_online, sbc_enter_online_active} <= 5'h00;
    wt(3);
  endtask : pls
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    wt(30000);
    err_total++;
    end_sim();
  end
  initial begin
    wt(20);
    rst <= 1'b0;
    wt(2);
    rd(12'h000);
    chk("tx_en", {14'h0, can_tx_enable, lin_tx_enable}, 16'h3);
    for (int i = 0; i < 3; i++) begin
      v = (i == 2) ? 12'h5a5 : 12'ha5a;
      sbc_normal_or_flash <= (i != 0);
      acc(4'hc, v);
      rd(v);
      chk("outs", {9'h0, can_tx_enable, can_active, can_split_drive, lin_active,
        lin_low_slope, lin_strong_drive, lin_tx_enable},
        {9'h0, ~v[8], v[6] & (i != 0), v[5], v[4] & (i != 0), v[3], v[2], ~v[0]});
      chk("loopback", {15'h0, can_rx_line}, {15'h0, ~(v[7] & v[8])});
    end
    acc(4'hd, 12'hfff);
    chk("ro_reply", rx, {4'h0, v});
    rd(v);
    acc(4'hf, 12'h000);
    chk("gp_reply", rx, 16'h03c9);
    acc(4'h8, 12'hfff);
    chk("other_reply", rx, 16'h0000);
    rd(v);
    acc(4'hc, 12'h002);
    lin_bus_wake <= 1'b1;
    wt(3);
    chk("lin_wake", {15'h0, lin_wakeup}, 16'h1);
    pls(0);
    chk("fail_tx", {15'h0, can_tx_enable}, 16'h0);
    rd(12'h002);
    pls(1);
    chk("good_tx", {15'h0, can_tx_enable}, 16'h1);
    pls(0);
    acc(4'hc, 12'h100);
    acc(4'hc, 12'h000);
    chk("rec_tx", {15'h0, can_tx_enable}, 16'h1);
    chk("lin_wake", {15'h0, lin_wakeup}, 16'h0);
    lin_bus_wake <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      acc(4'hc, {2'b11, j == 1, 9'h000});
      chk("reg_off", {14'h0, can_offline, can_transceiver_regulator}, 16'h2);
      can_bus_activity <= 1'b1;
      can_wake_event <= (j == 2);
      pls(2);
      chk("listen", {13'h0, can_offline, can_listen_only, can_transceiver_regulator}, 16'h3);
      can_bus_activity <= 1'b0;
      wt(j == 0 ? SHORT : (j == 1 ? LONG : EXT));
      chk("idle_on", {15'h0, can_offline}, 16'h0);
      wt(2);
      chk("idle_off", {15'h0, can_offline}, 16'h1);
    end
    acc(4'hc, 12'h400);
    can_bus_activity <= 1'b1;
    pls(2);
    chk("listen", {15'h0, can_listen_only}, 16'h1);
    pls(3);
    chk("pn_clear", {15'h0, can_listen_only}, 16'h0);
    rd(12'h000);
    end_sim();
  end
endmodule : testbench
